// ---- port_interface_mux.sv ----
// per-port phy signal mux, strap capture, power saving and register slave
`timescale 1ns/1ps
`default_nettype none
module port_interface_mux
   import port_mux_pkg::*;
#(
   parameter int unsigned TIMEOUT_LIMIT = TIMEOUT_CYCLES[TMO_W-1:0],
   parameter int unsigned IDLE_LIMIT = IDLE_CYCLES[IDLE_W-1:0]
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [DATA_W-1:0] avs_writedata_in,
   output logic [DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic irq_out,
   // strap pins
   input wire logic [STRAP_W-1:0] strap_pin_bus_in,
   // access port phy pins
   input wire logic [4*NUM_PORTS-1:0] phy_rxd_in,
   input wire logic [NUM_PORTS-1:0] access_port_carrier_valid_in,
   input wire logic [NUM_PORTS-1:0] phy_col_in,
   input wire logic [NUM_PORTS-1:0] access_port_tx_enable_strap_in,
   output logic [NUM_PORTS-1:0] access_port_tx_enable_strap_out,
   output logic [NUM_PORTS-1:0] access_port_tx_enable_strap_oe_out,
   output logic [4*NUM_PORTS-1:0] phy_txd_out,
   output logic [4*NUM_PORTS-1:0] rxd_pullup_out,
   output logic [NUM_PORTS-1:0] carrier_pullup_out,
   output logic [NUM_PORTS-1:0] clk_pullup_out,
   output logic [NUM_PORTS-1:0] col_pulldown_out,
   input wire logic [NUM_PORTS-1:0] module_present_in,
   // access port mac side
   input wire logic [4*NUM_PORTS-1:0] mac_txd_in,
   input wire logic [NUM_PORTS-1:0] mac_tx_en_in,
   output logic [4*NUM_PORTS-1:0] mac_rxd_out,
   output logic [NUM_PORTS-1:0] mac_carrier_out,
   output logic [NUM_PORTS-1:0] mac_col_out,
   output logic [2*NUM_PORTS-1:0] port_mode_out,
   output logic [NUM_PORTS-1:0] mac_low_power_out,
   // uplink phy pins and mac side
   input wire logic uplink_tx_clock_in,
   input wire logic [3:0] uplink_rxd_in,
   input wire logic uplink_rx_valid_in,
   input wire logic uplink_crs_in,
   input wire logic uplink_col_in,
   input wire logic [3:0] mac_uplink_txd_in,
   input wire logic mac_uplink_tx_en_in,
   output logic [3:0] uplink_txd_out,
   output logic uplink_tx_en_out,
   output logic [6:0] mac_uplink_rx_out,
   // boot configuration
   output logic cpu_frames_enable_out,
   output logic unmanaged_mode_out,
   output logic strobe_debounce_en_out,
   output logic [2:0] device_id_out,
   output logic eeprom_load_out,
   output logic module_detect_en_out,
   output logic power_save_en_out,
   output logic timeout_reset_en_out,
   output logic straps_valid_out,
   // stuck-state monitor
   input wire logic [NUM_SM-1:0] sm_busy_in,
   output logic reset_request_out
);
   localparam int SYNC_W = STRAP_W + 8 * NUM_PORTS + 7;

   function automatic port_mode_t pick_mode(input logic [4:0] cfg,
         input logic det_en, input logic type_bit);
      // with hot-swap on, the module type strap overrides software
      if (det_en) begin
         pick_mode = type_bit ? MODE_REDUCED : MODE_FULL;
      end else begin
         pick_mode = port_mode_t'(cfg[CFG_MODE_MSB:CFG_MODE_LSB]);
      end
   endfunction

   // synchronisers: first stage read only by second stage
   logic [SYNC_W-1:0] sync1_r, sync2_r;
   logic [2:0] lclk_r;
   logic [STRAP_W-1:0] strap_s;
   logic [NUM_PORTS-1:0] txen_s, crs_s, col_s, pres_s;
   logic [4*NUM_PORTS-1:0] rxd_s;
   logic [6:0] up_s;
   logic lclk_rise;

   assign {strap_s, txen_s, crs_s, col_s, pres_s, rxd_s, up_s} = sync2_r;
   assign lclk_rise = lclk_r[1] & ~lclk_r[2];

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_r <= '0;
         sync2_r <= '0;
         lclk_r <= '0;
      end else begin
         sync1_r <= {strap_pin_bus_in, access_port_tx_enable_strap_in,
                     access_port_carrier_valid_in, phy_col_in,
                     module_present_in, phy_rxd_in, uplink_rxd_in,
                     uplink_rx_valid_in, uplink_crs_in, uplink_col_in};
         sync2_r <= sync1_r;
         lclk_r <= {lclk_r[1:0], uplink_tx_clock_in};
      end
   end

   // strap capture
   logic [1:0] settle_r, settle_nxt;
   logic [STRAP_W-1:0] strap_r, strap_nxt;
   logic [NUM_PORTS-1:0] txstrap_r, txstrap_nxt;
   logic cap_r, cap_nxt;

   always_comb begin
      settle_nxt = settle_r;
      strap_nxt = strap_r;
      txstrap_nxt = txstrap_r;
      cap_nxt = cap_r;
      // wait for the synchronisers to fill, then capture exactly once
      if (!cap_r) begin
         if (settle_r == STRAP_SETTLE) begin
            strap_nxt = strap_s;
            txstrap_nxt = txen_s;
            cap_nxt = 1'b1;
         end else begin
            settle_nxt = settle_r + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         settle_r <= '0;
         strap_r <= STRAP_RST;
         txstrap_r <= TXEN_STRAP_RST;
         cap_r <= 1'b0;
      end else begin
         settle_r <= settle_nxt;
         strap_r <= strap_nxt;
         txstrap_r <= txstrap_nxt;
         cap_r <= cap_nxt;
      end
   end

   logic det_en, pwr_en, tmo_en;
   assign det_en = cap_r & strap_r[STRAP_MOD_DET];
   assign pwr_en = cap_r & strap_r[STRAP_PWR_SAVE];
   assign tmo_en = cap_r & strap_r[STRAP_TIMEOUT];

   // stuck-state monitor
   stuck_if mon_if ();
   assign mon_if.enable = tmo_en;
   assign mon_if.busy = sm_busy_in;

   stuck_monitor #(.LIMIT(TIMEOUT_LIMIT)) u_stuck (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .mon(mon_if.monitor)
   );

   // registers, bus slave and interrupts
   logic [4:0] cfg_r [NUM_PORTS];
   logic [4:0] cfg_nxt [NUM_PORTS];
   logic [IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
   logic wait_r, wait_nxt, irq_r, irq_nxt, rstreq_r, rstreq_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [NUM_PORTS-1:0] low_r, low_nxt, pres_q_r;
   logic req, wr_take;

   assign req = avs_read_in | avs_write_in;
   assign wr_take = avs_write_in & ~wait_r;

   always_comb begin
      wait_nxt = ~(req & wait_r);
      rdata_nxt = rdata_r;
      cfg_nxt = cfg_r;
      mask_nxt = mask_r;
      ev = '0;
      ev[IRQ_STUCK] = mon_if.stuck;
      ev[IRQ_MODULE] = det_en & |(pres_s ^ pres_q_r);
      ev[IRQ_LOW_POWER] = |(low_nxt & ~low_r);
      stat_nxt = stat_r;
      if (avs_read_in & wait_r) begin
         rdata_nxt = '0;
         case (avs_address_in)
            REG_STRAP: rdata_nxt = {7'h00, cap_r, txstrap_r, strap_r};
            REG_IRQ_STAT: rdata_nxt[IRQ_W-1:0] = stat_r;
            REG_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = mask_r;
            REG_PORT_STATE: rdata_nxt = {16'h0000, pres_q_r, low_r};
            REG_UPLINK_CFG: rdata_nxt = UPLINK_CFG_VAL;
            default: begin
               for (int p = 0; p < NUM_PORTS; p++) begin
                  if (avs_address_in == REG_PORT_CFG_BASE + ADDR_W'(4 * p)) begin
                     rdata_nxt[4:0] = cfg_r[p];
                  end
               end
            end
         endcase
      end
      if (wr_take) begin
         if (avs_address_in == REG_IRQ_STAT) begin
            stat_nxt = stat_r & ~avs_writedata_in[IRQ_W-1:0];
         end
         if (avs_address_in == REG_IRQ_MASK) begin
            mask_nxt = avs_writedata_in[IRQ_W-1:0];
         end
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (avs_address_in == REG_PORT_CFG_BASE + ADDR_W'(4 * p)) begin
               cfg_nxt[p] = avs_writedata_in[4:0];
            end
         end
      end
      // a new event beats a simultaneous clear
      stat_nxt = stat_nxt | ev;
      irq_nxt = |(stat_nxt & mask_nxt);
      rstreq_nxt = mon_if.stuck;
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            cfg_r[p] <= PORT_CFG_RST;
         end
         stat_r <= IRQ_RST;
         mask_r <= IRQ_RST;
         wait_r <= 1'b1;
         rdata_r <= '0;
         irq_r <= 1'b0;
         rstreq_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
         rstreq_r <= rstreq_nxt;
      end
   end

   // per-port mux, pulls and power saving
   logic [IDLE_W-1:0] idle_r [NUM_PORTS];
   logic [IDLE_W-1:0] idle_nxt [NUM_PORTS];
   logic [4*NUM_PORTS-1:0] rxd_o, txd_o, rpu_o;
   logic [NUM_PORTS-1:0] crs_o, col_o, cpu_o, kpu_o, cpd_o, ten_o, toe_o;
   logic [2*NUM_PORTS-1:0] mode_o;
   logic [3:0] up_txd_nxt;
   logic up_txen_nxt;

   always_comb begin
      port_mode_t m;
      m = MODE_REDUCED;
      for (int p = 0; p < NUM_PORTS; p++) begin
         m = pick_mode(cfg_r[p], det_en, txstrap_r[p]);
         mode_o[2*p +: 2] = m;
         rxd_o[4*p +: 4] = rxd_s[4*p +: 4];
         txd_o[4*p +: 4] = mac_txd_in[4*p +: 4];
         crs_o[p] = crs_s[p];
         col_o[p] = col_s[p];
         rpu_o[4*p +: 4] = 4'h0;
         cpu_o[p] = 1'b0;
         kpu_o[p] = 1'b0;
         cpd_o[p] = 1'b0;
         // strap pin stays released until the straps are captured
         ten_o[p] = mac_tx_en_in[p];
         toe_o[p] = cap_nxt;
         case (m)
            MODE_REDUCED: begin
               rxd_o[4*p +: 4] = {2'b00, rxd_s[4*p +: 2]};
               txd_o[4*p +: 4] = {2'b00, mac_txd_in[4*p +: 2]};
               col_o[p] = 1'b0;
               rpu_o[4*p +: 4] = 4'hC;
               kpu_o[p] = 1'b1;
               cpd_o[p] = 1'b1;
            end
            MODE_SERIAL: begin
               rxd_o[4*p +: 4] = {3'b000, rxd_s[4*p]};
               txd_o[4*p +: 4] = {3'b000, mac_txd_in[4*p]};
               rpu_o[4*p +: 4] = 4'hE;
            end
            MODE_FULL: begin
            end
            default: begin
               col_o[p] = 1'b0;
            end
         endcase
         // hot-swap on and nothing plugged: every input parked
         if (det_en && !pres_s[p]) begin
            rxd_o[4*p +: 4] = 4'h0;
            crs_o[p] = 1'b0;
            col_o[p] = 1'b0;
            rpu_o[4*p +: 4] = 4'hF;
            cpu_o[p] = 1'b1;
            kpu_o[p] = 1'b1;
            cpd_o[p] = 1'b1;
         end
         // low power entry after idle time, exit on any activity
         idle_nxt[p] = idle_r[p];
         low_nxt[p] = low_r[p];
         if (!pwr_en || crs_s[p] || mac_tx_en_in[p]) begin
            idle_nxt[p] = '0;
            low_nxt[p] = 1'b0;
         end else if (idle_r[p] == IDLE_W'(IDLE_LIMIT - 1)) begin
            low_nxt[p] = 1'b1;
         end else begin
            idle_nxt[p] = idle_r[p] + 1'b1;
         end
      end
      // uplink: full interface only, driven on each transmit clock rise
      up_txd_nxt = uplink_txd_out;
      up_txen_nxt = uplink_tx_en_out;
      if (lclk_rise) begin
         up_txd_nxt = mac_uplink_txd_in;
         up_txen_nxt = mac_uplink_tx_en_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            idle_r[p] <= '0;
         end
         low_r <= '0;
         pres_q_r <= '0;
         mac_rxd_out <= '0;
         phy_txd_out <= '0;
         mac_carrier_out <= '0;
         mac_col_out <= '0;
         port_mode_out <= '0;
         rxd_pullup_out <= '0;
         carrier_pullup_out <= '0;
         clk_pullup_out <= '0;
         col_pulldown_out <= '0;
         access_port_tx_enable_strap_out <= '0;
         access_port_tx_enable_strap_oe_out <= '0;
         uplink_txd_out <= '0;
         uplink_tx_en_out <= 1'b0;
         mac_uplink_rx_out <= '0;
      end else begin
         idle_r <= idle_nxt;
         low_r <= low_nxt;
         pres_q_r <= pres_s;
         mac_rxd_out <= rxd_o;
         phy_txd_out <= txd_o;
         mac_carrier_out <= crs_o;
         mac_col_out <= col_o;
         port_mode_out <= mode_o;
         rxd_pullup_out <= rpu_o;
         carrier_pullup_out <= cpu_o;
         clk_pullup_out <= kpu_o;
         col_pulldown_out <= cpd_o;
         access_port_tx_enable_strap_out <= ten_o;
         access_port_tx_enable_strap_oe_out <= toe_o;
         uplink_txd_out <= up_txd_nxt;
         uplink_tx_en_out <= up_txen_nxt;
         mac_uplink_rx_out <= up_s;
      end
   end

   // boot configuration outputs, all registered
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cpu_frames_enable_out <= 1'b0;
         unmanaged_mode_out <= 1'b0;
         strobe_debounce_en_out <= 1'b0;
         device_id_out <= '0;
         eeprom_load_out <= 1'b0;
         module_detect_en_out <= 1'b0;
         power_save_en_out <= 1'b0;
         timeout_reset_en_out <= 1'b0;
         straps_valid_out <= 1'b0;
      end else begin
         cpu_frames_enable_out <= cap_nxt & ~strap_nxt[STRAP_MGMT];
         unmanaged_mode_out <= cap_nxt & strap_nxt[STRAP_MGMT];
         strobe_debounce_en_out <= cap_nxt & strap_nxt[STRAP_DEBOUNCE];
         device_id_out <= strap_nxt[STRAP_ID_MSB:STRAP_ID_LSB];
         eeprom_load_out <= cap_nxt & strap_nxt[STRAP_MGMT]
            & ~strap_nxt[STRAP_NO_EEPROM];
         module_detect_en_out <= cap_nxt & strap_nxt[STRAP_MOD_DET];
         power_save_en_out <= cap_nxt & strap_nxt[STRAP_PWR_SAVE];
         timeout_reset_en_out <= cap_nxt & strap_nxt[STRAP_TIMEOUT];
         straps_valid_out <= cap_nxt;
      end
   end

   assign avs_readdata_out = rdata_r;
   assign avs_waitrequest_out = wait_r;
   assign irq_out = irq_r;
   assign reset_request_out = rstreq_r;
   assign mac_low_power_out = low_r;
endmodule
`default_nettype wire

// ---- port_mux_pkg.sv ----
// shared constants and types for the port interface mux and strap block
package port_mux_pkg;
   localparam int NUM_PORTS = 8;
   localparam int NUM_SM = 4;
   localparam int STRAP_W = 16;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;

   typedef enum logic [1:0] {
      MODE_SERIAL = 2'b00,
      MODE_FULL = 2'b01,
      MODE_SPARE = 2'b10,
      MODE_REDUCED = 2'b11
   } port_mode_t;

   // strap bit positions
   localparam int STRAP_DEBOUNCE = 0;
   localparam int STRAP_MGMT = 3;
   localparam int STRAP_ID_LSB = 4;
   localparam int STRAP_ID_MSB = 6;
   localparam int STRAP_NO_EEPROM = 7;
   localparam int STRAP_MOD_DET = 9;
   localparam int STRAP_PWR_SAVE = 11;
   localparam int STRAP_TIMEOUT = 12;
   localparam logic [STRAP_W-1:0] STRAP_RST = 16'h0000;
   localparam logic [NUM_PORTS-1:0] TXEN_STRAP_RST = 8'h00;

   // mode field in port_interface_config
   localparam int CFG_MODE_LSB = 3;
   localparam int CFG_MODE_MSB = 4;
   localparam logic [4:0] PORT_CFG_RST = 5'h18;
   localparam logic [DATA_W-1:0] UPLINK_CFG_VAL = 32'h0000_0018;

   // register byte offsets
   localparam logic [ADDR_W-1:0] REG_STRAP = 6'h00;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 6'h04;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 6'h08;
   localparam logic [ADDR_W-1:0] REG_PORT_STATE = 6'h0C;
   localparam logic [ADDR_W-1:0] REG_UPLINK_CFG = 6'h10;
   localparam logic [ADDR_W-1:0] REG_PORT_CFG_BASE = 6'h20;

   // interrupt status bits
   localparam int IRQ_W = 3;
   localparam int IRQ_STUCK = 0;
   localparam int IRQ_MODULE = 1;
   localparam int IRQ_LOW_POWER = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // timing
   localparam longint unsigned CLK_HZ = 64'd250_000_000;
   localparam longint unsigned TIMEOUT_SEC = 64'd5;
   localparam longint unsigned TIMEOUT_CYCLES = TIMEOUT_SEC * CLK_HZ;
   localparam longint unsigned IDLE_US = 64'd100;
   localparam longint unsigned IDLE_CYCLES = IDLE_US * CLK_HZ / 64'd1_000_000;
   localparam int TMO_W = 32;
   localparam int IDLE_W = 24;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage

// ---- stuck_if.sv ----
// link between the switch logic and the stuck-state monitor
`timescale 1ns/1ps
`default_nettype none
interface stuck_if;
   import port_mux_pkg::*;
   logic enable;
   logic [NUM_SM-1:0] busy;
   logic stuck;
   modport monitor (input enable, input busy, output stuck);
   modport host (output enable, output busy, input stuck);
endinterface
`default_nettype wire

// ---- stuck_monitor.sv ----
// per-machine non-idle timer that flags a state machine stuck too long
`timescale 1ns/1ps
`default_nettype none
module stuck_monitor
   import port_mux_pkg::*;
#(
   parameter int unsigned LIMIT = TIMEOUT_CYCLES[TMO_W-1:0]
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // monitored machines
   stuck_if.monitor mon
);
   logic [TMO_W-1:0] cnt_r [NUM_SM];
   logic [TMO_W-1:0] cnt_nxt [NUM_SM];
   logic stuck_r;
   logic stuck_nxt;

   assign mon.stuck = stuck_r;

   always_comb begin
      stuck_nxt = 1'b0;
      for (int i = 0; i < NUM_SM; i++) begin
         cnt_nxt[i] = cnt_r[i];
         if (!mon.enable || !mon.busy[i]) begin
            cnt_nxt[i] = '0;
         end else if (cnt_r[i] != LIMIT) begin
            cnt_nxt[i] = cnt_r[i] + 1'b1;
            // one pulse when the limit is crossed, counter then saturates
            if (cnt_nxt[i] == LIMIT) begin
               stuck_nxt = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NUM_SM; i++) begin
            cnt_r[i] <= '0;
         end
         stuck_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         stuck_r <= stuck_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- port_interface_mux_checker.sv ----
// concurrent checks on the port mux top-level ports
`timescale 1ns/1ps
`default_nettype none
module port_interface_mux_checker
   import port_mux_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // watched ports
   input wire logic [NUM_PORTS-1:0] mac_tx_en_in,
   input wire logic [NUM_PORTS-1:0] access_port_tx_enable_strap_oe_out,
   input wire logic [4*NUM_PORTS-1:0] rxd_pullup_out,
   input wire logic [NUM_PORTS-1:0] col_pulldown_out,
   input wire logic [2*NUM_PORTS-1:0] port_mode_out,
   input wire logic [NUM_PORTS-1:0] mac_low_power_out,
   input wire logic cpu_frames_enable_out,
   input wire logic unmanaged_mode_out,
   input wire logic [2:0] device_id_out,
   input wire logic eeprom_load_out,
   input wire logic module_detect_en_out,
   input wire logic timeout_reset_en_out,
   input wire logic straps_valid_out,
   input wire logic reset_request_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   property p_oe;
      straps_valid_out |-> &access_port_tx_enable_strap_oe_out;
   endproperty
   a_oe: assert property (p_oe)
      else $error("pin enable low after capture");
   property p_hold;
      straps_valid_out && $past(straps_valid_out) |->
         $stable({unmanaged_mode_out, device_id_out, eeprom_load_out});
   endproperty
   a_hold: assert property (p_hold)
      else $error("boot settings moved");
   property p_frames;
      straps_valid_out |-> cpu_frames_enable_out != unmanaged_mode_out;
   endproperty
   a_frames: assert property (p_frames)
      else $error("frame enable wrong");
   property p_eeprom;
      eeprom_load_out |-> unmanaged_mode_out;
   endproperty
   a_eeprom: assert property (p_eeprom)
      else $error("eeprom load while managed");
   property p_pull;
      straps_valid_out && !module_detect_en_out |->
         col_pulldown_out[0] == (port_mode_out[1:0] == 2'b11) &&
         rxd_pullup_out[3:0] == (port_mode_out[1:0] == 2'b11 ? 4'hC :
         port_mode_out[1:0] == 2'b00 ? 4'hE : 4'h0);
   endproperty
   a_pull: assert property (p_pull)
      else $error("pull enables do not match mode");
   property p_lp_exit;
      mac_tx_en_in[1] |=> !mac_low_power_out[1];
   endproperty
   a_lp_exit: assert property (p_lp_exit)
      else $error("low power kept during activity");
   property p_req_pulse;
      reset_request_out |=> !reset_request_out;
   endproperty
   a_req_pulse: assert property (p_req_pulse)
      else $error("reset request longer than a cycle");
   property p_req_en;
      reset_request_out |-> timeout_reset_en_out;
   endproperty
   a_req_en: assert property (p_req_en)
      else $error("reset request while monitor off");
endmodule
bind port_interface_mux port_interface_mux_checker
   port_interface_mux_checker_inst (.*);
`default_nettype wire

// ---- phy_model.sv ----
// behavioural uplink phy; its transmit clock runs only within frames
`timescale 1ns/1ps
`default_nettype none
module phy_model (
   // bench control
   input wire logic frame_in,
   input wire logic [3:0] nib_in,
   // link
   input wire logic [3:0] txd_in,
   output logic tx_clk_out = 1'b0,
   output logic [3:0] rxd_out = 4'h0,
   output logic dv_out = 1'b0,
   output logic [3:0] seen_out = 4'h0
);
   logic [3:0] last = 4'h0;
   // half period lands on a falling core edge, never on a sampling one
   always begin
      #80;
      tx_clk_out = frame_in ? ~tx_clk_out : 1'b0;
   end
   // released data shows the inverse, not a stale copy
   always @(frame_in or nib_in) begin
      if (frame_in)
         last = nib_in;
      rxd_out = frame_in ? nib_in : ~last;
      dv_out = frame_in;
   end
   always @(posedge tx_clk_out)
      seen_out <= txd_in;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the port interface mux and strap capture
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import port_mux_pkg::*;
   localparam int TMO = 50;
   localparam int IDL = 10;
   localparam logic [15:0] S1 = 16'hF9D7;
   localparam logic [15:0] S2 = 16'hE32E;
   localparam logic [7:0] TXS = 8'hA5;
   int fails = 0;
   int checks = 0;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [ADDR_W-1:0] avs_address_in = '0;
   logic avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out;
   logic [DATA_W-1:0] avs_writedata_in = '0, avs_readdata_out, rd;
   logic irq_out, uplink_tx_clock_in, uplink_rx_valid_in, frame = 1'b0;
   logic [STRAP_W-1:0] strap_pin_bus_in = S1;
   logic [4*NUM_PORTS-1:0] phy_rxd_in = '0, mac_txd_in = '0, phy_txd_out;
   logic [4*NUM_PORTS-1:0] rxd_pullup_out, mac_rxd_out;
   logic [NUM_PORTS-1:0] access_port_carrier_valid_in = '0, phy_col_in = '0;
   logic [NUM_PORTS-1:0] module_present_in = '1, mac_tx_en_in = '0;
   logic [NUM_PORTS-1:0] pull = TXS, access_port_tx_enable_strap_out;
   logic [NUM_PORTS-1:0] access_port_tx_enable_strap_oe_out, mac_col_out;
   logic [NUM_PORTS-1:0] carrier_pullup_out, clk_pullup_out, col_pulldown_out;
   logic [NUM_PORTS-1:0] mac_carrier_out, mac_low_power_out;
   wire logic [NUM_PORTS-1:0] access_port_tx_enable_strap_in;
   logic [2*NUM_PORTS-1:0] port_mode_out;
   logic [3:0] uplink_rxd_in, mac_uplink_txd_in = '0, uplink_txd_out, seen;
   logic [3:0] nib = 4'h0;
   logic uplink_crs_in = 1'b0, uplink_col_in = 1'b0, uplink_tx_en_out;
   logic mac_uplink_tx_en_in = 1'b0;
   logic [6:0] mac_uplink_rx_out;
   logic cpu_frames_enable_out, unmanaged_mode_out, strobe_debounce_en_out;
   logic [2:0] device_id_out;
   logic eeprom_load_out, module_detect_en_out, power_save_en_out;
   logic timeout_reset_en_out, straps_valid_out, reset_request_out;
   logic [NUM_SM-1:0] sm_busy_in = '0;
   // two-way strap pin: external pull unless the device drives it
   assign access_port_tx_enable_strap_in =
      (access_port_tx_enable_strap_oe_out & access_port_tx_enable_strap_out)
      | (~access_port_tx_enable_strap_oe_out & pull);
   always #2 core_clk_in = ~core_clk_in;
   port_interface_mux #(.TIMEOUT_LIMIT(TMO), .IDLE_LIMIT(IDL))
      port_interface_mux_inst (.*);
   phy_model phy_model_inst (.frame_in(frame), .nib_in(nib),
      .txd_in(uplink_txd_out), .tx_clk_out(uplink_tx_clock_in),
      .rxd_out(uplink_rxd_in), .dv_out(uplink_rx_valid_in), .seen_out(seen));
   task automatic report_and_stop;
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      int n = 0;
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= !wr;
      avs_write_in <= wr;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      chk(n < 50, 1);
   endtask
   task automatic do_reset(input logic [15:0] s);
      @(posedge core_clk_in);
      rst_n_in <= 1'b0;
      strap_pin_bus_in <= s;
      cyc(16);
      rst_n_in <= 1'b1;
      cyc(8);
   endtask
   task automatic chk_boot(input logic [15:0] s);
      chk(straps_valid_out, 1);
      chk(unmanaged_mode_out, s[3]);
      chk(cpu_frames_enable_out, !s[3]);
      chk(strobe_debounce_en_out, s[0]);
      chk(device_id_out, {s[6], s[5], s[4]});
      chk(eeprom_load_out, s[3] & !s[7]);
      chk(module_detect_en_out, s[9]);
      chk(power_save_en_out, s[11]);
      chk(timeout_reset_en_out, s[12]);
      bus(0, REG_STRAP, 0);
      chk(rd, {7'h0, 1'b1, TXS, s});
   endtask
   task automatic t_straps;
      do_reset(S2);
      chk_boot(S2);
      chk(port_mode_out[3:0], 4'b0111);
      chk(mac_low_power_out, 0);
      module_present_in[2] <= 1'b0;
      cyc(6);
      chk(rxd_pullup_out[11:8], 4'hF);
      chk(carrier_pullup_out[2], 1);
      chk(col_pulldown_out[2], 1);
      bus(0, REG_IRQ_STAT, 0);
      chk(rd, 32'h2);
      module_present_in[2] <= 1'b1;
      do_reset(S1);
      chk_boot(S1);
      strap_pin_bus_in <= ~S1;
      pull <= ~TXS;
      cyc(8);
      chk_boot(S1);
   endtask
   task automatic t_modes;
      logic [1:0] m [3] = '{2'b11, 2'b01, 2'b00};
      logic [3:0] pu [3] = '{4'hC, 4'h0, 4'hE};
      logic [3:0] rx [3] = '{4'h3, 4'hF, 4'h1};
      phy_rxd_in <= 32'hFFFF_FFFF;
      mac_txd_in <= 32'hFFFF_FFFF;
      for (int i = 0; i < 3; i++) begin
         bus(1, REG_PORT_CFG_BASE, {27'h0, m[i], 3'h0});
         cyc(4);
         chk(port_mode_out[1:0], m[i]);
         chk(rxd_pullup_out[3:0], pu[i]);
         chk(col_pulldown_out[0], m[i] == 2'b11);
         chk(clk_pullup_out[0], m[i] == 2'b11);
         chk(mac_rxd_out[3:0], rx[i]);
         chk(phy_txd_out[3:0], rx[i]);
         bus(0, REG_PORT_CFG_BASE, 0);
         chk(rd[4:3], m[i]);
      end
   endtask
   task automatic t_uplink;
      bus(0, REG_UPLINK_CFG, 0);
      chk(rd, 32'h0000_0018);
      mac_uplink_txd_in <= 4'h9;
      mac_uplink_tx_en_in <= 1'b1;
      nib <= 4'h6;
      frame <= 1'b1;
      cyc(200);
      chk(seen, 4'h9);
      chk(uplink_tx_en_out, 1);
      chk(mac_uplink_rx_out[6:2], 5'h0D);
      frame <= 1'b0;
      mac_uplink_tx_en_in <= 1'b0;
   endtask
   task automatic t_lowpower;
      chk(mac_low_power_out[1], 1);
      mac_tx_en_in[1] <= 1'b1;
      cyc(3);
      chk(mac_low_power_out[1], 0);
      mac_tx_en_in[1] <= 1'b0;
      cyc(IDL - 4);
      chk(mac_low_power_out[1], 0);
      cyc(10);
      chk(mac_low_power_out[1], 1);
   endtask
   task automatic t_stuck;
      int n = 0;
      chk(irq_out, 0);
      bus(1, REG_IRQ_MASK, 32'h1);
      sm_busy_in <= 4'h1;
      while (reset_request_out !== 1'b1 && n < 200) begin
         @(posedge core_clk_in);
         n++;
      end
      chk(n >= TMO - 2 && n <= TMO + 4, 1);
      sm_busy_in <= 4'h0;
      cyc(2);
      chk(irq_out, 1);
      bus(0, REG_IRQ_STAT, 0);
      chk(rd[0], 1);
      bus(1, REG_IRQ_STAT, 32'h1);
      cyc(2);
      chk(irq_out, 0);
      bus(0, 6'h14, 0);
      chk(rd, 0);
   endtask
   initial begin
      t_straps;
      t_modes;
      t_uplink;
      t_lowpower;
      t_stuck;
      report_and_stop;
   end
   // the tests need about 1.6 us; this cuts a hang short
   initial begin
      #100000;
      fails++;
      report_and_stop;
   end
endmodule
`default_nettype wire
